// ==== common/cmdq_fault_params.svh ====
/*
  register map, field positions, reset values and reason codes
  of the command queue fault handler; included by design files.
*/
`ifndef CMDQ_FAULT_PARAMS_SVH
`define CMDQ_FAULT_PARAMS_SVH

`define AXI_AW 8
`define OFS_WPTR 8'h00
`define OFS_RPTR 8'h04
`define OFS_CTRL 8'h08
`define OFS_GSTAT 8'h0c
`define OFS_GACK 8'h10
`define OFS_ISTAT 8'h14
`define OFS_IEN 8'h18
`define OFS_ICLR 8'h1c

`define RP_ERR_LSB 24
`define GF_QUEUE_BIT 0
`define CTL_EN_BIT 0
`define IRQ_FAULT_BIT 0
`define IRQ_DRAIN_BIT 1
`define IRQ_W 2

`define RST_WORD 32'h0000_0000
`define RST_IRQ 2'h0

`define CODE_NONE 8'h00
`define CODE_BAD_CMD 8'h01
`define CODE_FETCH_ABT 8'h02
`define CODE_INV_TMO 8'h03

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== common/cmdq_fault_pkg.sv ====
/*
  types shared by the command queue fault handler files.
  assumes nothing of its surroundings.
*/
package cmdq_fault_pkg;

  // gray codes along idle-fetch-wait-exec and exec-log-halt
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_WAIT  = 3'h3,
    ST_EXEC  = 3'h2,
    ST_LOG   = 3'h6,
    ST_HALT  = 3'h7
  } state_e;

  typedef logic [7:0] fault_code_t;

endpackage : cmdq_fault_pkg

// ==== rtl/command_screen.sv ====
/*
  legality check of one fetched command word.
  assumes the opcode sits in the low byte of the word.
*/
`timescale 1ns/100ps

module command_screen #(
  parameter int          CMD_W       = 64,
  parameter logic [15:0] KNOWN_OPS   = 16'h00ff,
  parameter logic [15:0] PRESENT_OPS = 16'h00ff,
  parameter logic [15:0] SECURE_OPS  = 16'h0080,
  parameter logic [63:0] RSVD_MASK   = 64'hffff_0000_0000_0000
) (
  // command
  input  wire logic [CMD_W-1:0] cmd,
  input  wire logic             secure_queue,
  // verdict
  output logic                  bad
);

  wire [7:0] opcode   = cmd[7:0];
  wire       in_range = opcode[7:4] == 4'h0;
  wire       known    = in_range && KNOWN_OPS[opcode[3:0]];
  // missing feature or wrong security state counts as unknown
  wire       absent   = !PRESENT_OPS[opcode[3:0]] ||
                        (SECURE_OPS[opcode[3:0]] && !secure_queue);
  wire       rsvd_use = |(cmd & RSVD_MASK[CMD_W-1:0]);

  assign bad = !known || absent || rsvd_use;

endmodule : command_screen

// ==== rtl/axil_reg_port.sv ====
/*
  axi4-lite slave front end: one write and one read at a time.
  assumes read data and write error are decoded by the parent.
*/
`timescale 1ns/100ps
`include "cmdq_fault_params.svh"

module axil_reg_port (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // axi4-lite
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // register side
  output logic                   reg_wr,
  output logic [`AXI_AW-1:0]     reg_waddr,
  output logic [31:0]            reg_wdata,
  output logic [3:0]             reg_wstrb,
  input  wire logic              wr_err,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic               aw_free_q, w_free_q, ar_free_q;
  logic               bvalid_q, rvalid_q;
  logic [1:0]         bresp_q, rresp_q;
  logic [31:0]        rdata_q, wdata_q;
  logic [3:0]         wstrb_q;
  logic [`AXI_AW-1:0] waddr_q;

  wire aw_take = awvalid && aw_free_q;
  wire w_take  = wvalid && w_free_q;
  wire fire    = !aw_free_q && !w_free_q && !bvalid_q;
  wire ar_take = arvalid && ar_free_q;
  wire b_done  = bvalid_q && bready;
  wire r_done  = rvalid_q && rready;

  assign awready   = aw_free_q;
  assign wready    = w_free_q;
  assign arready   = ar_free_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign rvalid    = rvalid_q;
  assign rresp     = rresp_q;
  assign rdata     = rdata_q;
  assign reg_wr    = fire;
  assign reg_waddr = waddr_q;
  assign reg_wdata = wdata_q;
  assign reg_wstrb = wstrb_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_free_q <= 1'b1;
      w_free_q  <= 1'b1;
      waddr_q   <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_free_q <= 1'b0;
        waddr_q   <= awaddr;
      end
      else if (fire)
        aw_free_q <= 1'b1;
      if (w_take)
      begin
        w_free_q <= 1'b0;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      else if (fire)
        w_free_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end
    else if (fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (b_done)
      bvalid_q <= 1'b0;
  end

  // read data is captured at the address handshake
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ar_free_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= '0;
    end
    else if (ar_take)
    begin
      ar_free_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      rdata_q   <= rd_data;
    end
    else if (r_done)
    begin
      ar_free_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

endmodule : axil_reg_port

// ==== rtl/command_queue_error_handler.sv ====
/*
  command queue consumer with fault stop, reason code and restart.
  assumes one fetch in flight, memory answers each fetch once, and
  the executor raises exec_done once per offered command.
*/
// Chosen here: the AXI4-Lite register port and the address map.
//
// Behaviour
// - consume in order, stop on fault
// - older commands complete before fault report
// - read index stays on faulty slot
// - fetch abort never advances read index
// - reason code visible before fault flag
// - flag set, no consumption while active
// - younger commands discarded, no effect
// - acknowledge alone restarts processing
// - restart refetches from frozen index
// - illegal command gives code one
// - absent feature opcode treated as unknown
// - fetch abort gives code two
// - failed invalidation sync gives code three
// - code zero never reported for faults
`timescale 1ns/100ps
`include "cmdq_fault_params.svh"

module command_queue_error_handler #(
  parameter int       IDX_W       = 8,
  parameter int       CMD_W       = 64,
  parameter bit       ABORT_CAPABLE = 1'b1
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // axi4-lite register bus
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [`AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // command fetch
  output logic                   fetch_valid,
  output logic [IDX_W-1:0]       fetch_index,
  input  wire logic              fetch_ready,
  input  wire logic              rsp_valid,
  input  wire logic [CMD_W-1:0]  rsp_data,
  input  wire logic              rsp_abort,
  // command execution
  output logic                   exec_valid,
  output logic [CMD_W-1:0]       exec_cmd,
  input  wire logic              exec_done,
  input  wire logic              exec_sync_fail,
  // misc
  input  wire logic              secure_queue,
  output logic                   irq
);

  localparam int PW = IDX_W + 1;

  cmdq_fault_pkg::state_e      state_q, state_d;
  logic [PW-1:0]               wr_ptr_q, rd_ptr_q;
  cmdq_fault_pkg::fault_code_t err_code_q;
  logic                        fault_tog_q, ack_q, enable_q;
  logic [`IRQ_W-1:0]           istat_q, ien_q;
  logic                        irq_q, fetch_valid_q, exec_valid_q;
  logic [IDX_W-1:0]            fetch_idx_q;
  logic [CMD_W-1:0]            exec_cmd_q;
  logic                        reg_wr, cmd_bad;
  logic [`AXI_AW-1:0]          reg_waddr;
  logic [31:0]                 reg_wdata;
  logic [3:0]                  reg_wstrb;

  function automatic logic [31:0] apply_strb(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_w[8*i +: 8];
    return r;
  endfunction : apply_strb

  function automatic logic is_mapped(input logic [`AXI_AW-1:0] a);
    return a == `OFS_WPTR || a == `OFS_RPTR || a == `OFS_CTRL ||
           a == `OFS_GSTAT || a == `OFS_GACK || a == `OFS_ISTAT ||
           a == `OFS_IEN || a == `OFS_ICLR;
  endfunction : is_mapped

  // register decode and read mux
  wire wr_wptr = reg_wr && reg_waddr == `OFS_WPTR;
  wire wr_ctrl = reg_wr && reg_waddr == `OFS_CTRL;
  wire wr_gack = reg_wr && reg_waddr == `OFS_GACK;
  wire wr_ien  = reg_wr && reg_waddr == `OFS_IEN;
  wire wr_iclr = reg_wr && reg_waddr == `OFS_ICLR;
  wire wr_err  = reg_wr && !is_mapped(reg_waddr);
  wire rd_err  = !is_mapped(araddr);

  wire [31:0] wptr_word = 32'(wr_ptr_q);
  wire [31:0] rptr_word = 32'(rd_ptr_q) |
                          (32'(err_code_q) << `RP_ERR_LSB);
  wire [31:0] ctrl_word = 32'(enable_q) << `CTL_EN_BIT;
  wire [31:0] gst_word  = 32'(fault_tog_q) << `GF_QUEUE_BIT;
  wire [31:0] gack_word = 32'(ack_q) << `GF_QUEUE_BIT;
  wire [31:0] wptr_new  = apply_strb(wptr_word, reg_wdata, reg_wstrb);
  wire [31:0] ctrl_new  = apply_strb(ctrl_word, reg_wdata, reg_wstrb);
  wire [31:0] gack_new  = apply_strb(gack_word, reg_wdata, reg_wstrb);
  wire [31:0] ien_new   = apply_strb(32'(ien_q), reg_wdata, reg_wstrb);
  wire [`IRQ_W-1:0] iclr_bits = reg_wstrb[0] ?
                                reg_wdata[`IRQ_W-1:0] : `RST_IRQ;

  wire [31:0] rd_word =
    (araddr == `OFS_WPTR)  ? wptr_word :
    (araddr == `OFS_RPTR)  ? rptr_word :
    (araddr == `OFS_CTRL)  ? ctrl_word :
    (araddr == `OFS_GSTAT) ? gst_word :
    (araddr == `OFS_GACK)  ? gack_word :
    (araddr == `OFS_ISTAT) ? 32'(istat_q) :
    (araddr == `OFS_IEN)   ? 32'(ien_q) : `RST_WORD;

  // queue control
  wire in_idle  = state_q == cmdq_fault_pkg::ST_IDLE;
  wire in_wait  = state_q == cmdq_fault_pkg::ST_WAIT;
  wire in_exec  = state_q == cmdq_fault_pkg::ST_EXEC;
  wire in_log   = state_q == cmdq_fault_pkg::ST_LOG;
  wire in_halt  = state_q == cmdq_fault_pkg::ST_HALT;
  // active while status and acknowledge disagree
  wire fault_active = fault_tog_q ^ ack_q;
  wire q_empty   = rd_ptr_q == wr_ptr_q;
  wire start_fetch = in_idle && enable_q && !fault_active &&
                     !q_empty;
  wire abort_hit = ABORT_CAPABLE && rsp_valid && rsp_abort;
  wire rsp_fault = abort_hit || cmd_bad;
  wire rsp_raise = in_wait && rsp_valid && rsp_fault;
  wire sync_raise = in_exec && exec_done && exec_sync_fail;
  wire raise     = rsp_raise || sync_raise;
  // only a completed command advances the index
  wire consume   = in_exec && exec_done && !exec_sync_fail;
  wire [PW-1:0] rd_ptr_inc = PW'(rd_ptr_q + 1'b1);
  wire drained   = consume && rd_ptr_inc == wr_ptr_q;
  // abort wins over the legality check of a garbage word
  wire [7:0] new_code = sync_raise ? `CODE_INV_TMO :
                        abort_hit ? `CODE_FETCH_ABT :
                        `CODE_BAD_CMD;
  wire [`IRQ_W-1:0] ev_bits = (`IRQ_W'(in_log) << `IRQ_FAULT_BIT) |
                              (`IRQ_W'(drained) << `IRQ_DRAIN_BIT);
  wire [`IRQ_W-1:0] istat_d = ev_bits | (istat_q & ~(wr_iclr ?
                              iclr_bits : `RST_IRQ));

  assign fetch_valid = fetch_valid_q;
  assign fetch_index = fetch_idx_q;
  assign exec_valid  = exec_valid_q;
  assign exec_cmd    = exec_cmd_q;
  assign irq         = irq_q;

  axil_reg_port u_port (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .wr_err    (wr_err),
    .rd_data   (rd_word),
    .rd_err    (rd_err)
  );

  command_screen #(
    .CMD_W (CMD_W)
  ) u_screen (
    .cmd          (rsp_data),
    .secure_queue (secure_queue),
    .bad          (cmd_bad)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      cmdq_fault_pkg::ST_IDLE:
        if (start_fetch)
          state_d = cmdq_fault_pkg::ST_FETCH;
      cmdq_fault_pkg::ST_FETCH:
        if (fetch_ready)
          state_d = cmdq_fault_pkg::ST_WAIT;
      cmdq_fault_pkg::ST_WAIT:
        if (rsp_valid)
          state_d = rsp_fault ? cmdq_fault_pkg::ST_LOG :
                                cmdq_fault_pkg::ST_EXEC;
      cmdq_fault_pkg::ST_EXEC:
        if (exec_done)
          state_d = exec_sync_fail ? cmdq_fault_pkg::ST_LOG :
                                     cmdq_fault_pkg::ST_IDLE;
      cmdq_fault_pkg::ST_LOG:
        state_d = cmdq_fault_pkg::ST_HALT;
      cmdq_fault_pkg::ST_HALT:
        if (!fault_active)
          state_d = cmdq_fault_pkg::ST_IDLE;
      default:
        state_d = cmdq_fault_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= cmdq_fault_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // index frozen on any fault, including aborts
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_ptr_q <= '0;
    else if (consume)
      rd_ptr_q <= rd_ptr_inc;
  end

  // rewinds while halted are accepted as written
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      wr_ptr_q <= '0;
    else if (wr_wptr)
      wr_ptr_q <= wptr_new[PW-1:0];
  end

  // code lands a cycle before the flag flips
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_code_q  <= `CODE_NONE;
      fault_tog_q <= 1'b0;
    end
    else
    begin
      if (raise)
        err_code_q <= new_code;
      if (in_log)
        fault_tog_q <= !fault_tog_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q    <= 1'b0;
      enable_q <= 1'b0;
      ien_q    <= `RST_IRQ;
    end
    else
    begin
      if (wr_gack)
        ack_q <= gack_new[`GF_QUEUE_BIT];
      if (wr_ctrl)
        enable_q <= ctrl_new[`CTL_EN_BIT];
      if (wr_ien)
        ien_q <= ien_new[`IRQ_W-1:0];
    end
  end

  // a new event outweighs a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      istat_q <= `RST_IRQ;
      irq_q   <= 1'b0;
    end
    else
    begin
      istat_q <= istat_d;
      irq_q   <= |(istat_d & ien_q);
    end
  end

  // one command in flight, so nothing younger is ever held
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fetch_valid_q <= 1'b0;
      fetch_idx_q   <= '0;
    end
    else if (start_fetch)
    begin
      fetch_valid_q <= 1'b1;
      fetch_idx_q   <= rd_ptr_q[IDX_W-1:0];
    end
    else if (fetch_ready)
      fetch_valid_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exec_valid_q <= 1'b0;
      exec_cmd_q   <= '0;
    end
    else if (in_wait && rsp_valid && !rsp_fault)
    begin
      exec_valid_q <= 1'b1;
      exec_cmd_q   <= rsp_data;
    end
    else if (exec_done)
      exec_valid_q <= 1'b0;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_code_then_flag;
    in_log && err_code_q != `CODE_NONE ##1 in_halt && fault_active;
  endsequence

  chk_code_first: assert property (
    raise |=> s_code_then_flag)
    else $error("fault flag not preceded by its code");
  chk_code_nonzero: assert property (
    fault_active |-> err_code_q != `CODE_NONE)
    else $error("fault reported with code zero");
  chk_halt_quiet: assert property (
    fault_active |-> !fetch_valid_q && !exec_valid_q)
    else $error("queue consumed while fault active");
  chk_index_frozen: assert property (
    raise |=> ($stable(rd_ptr_q))[*2])
    else $error("read index moved on fault");
  chk_abort_no_inc: assert property (
    in_wait && abort_hit |=> $stable(rd_ptr_q) ##1 err_code_q ==
      `CODE_FETCH_ABT)
    else $error("fetch abort advanced index or wrong code");
  chk_ill_code: assert property (
    in_wait && rsp_valid && !abort_hit && cmd_bad |=>
      err_code_q == `CODE_BAD_CMD)
    else $error("illegal command code wrong");
  chk_sync_code: assert property (
    sync_raise |=> err_code_q == `CODE_INV_TMO && in_log)
    else $error("sync failure code wrong");
  chk_in_order: assert property (
    consume |=> rd_ptr_q == PW'($past(rd_ptr_q) + 1'b1))
    else $error("index did not advance by one");
  chk_discard_young: assert property (
    rsp_valid && (rsp_raise || in_halt) |=> !exec_valid_q)
    else $error("command after fault reached executor");
  chk_restart: assert property (
    in_halt && !fault_active && enable_q && !q_empty && !wr_wptr |=>
      ##[1:2] fetch_valid_q)
    else $error("no refetch after acknowledge");
  chk_refetch_idx: assert property (
    $rose(fetch_valid_q) |-> fetch_idx_q == rd_ptr_q[IDX_W-1:0])
    else $error("fetch not from read index");
  chk_ack_clear: assert property (
    wr_gack && gack_new[`GF_QUEUE_BIT] == fault_tog_q && !in_log |=>
      !fault_active)
    else $error("matching acknowledge did not clear fault");

endmodule : command_queue_error_handler

// ==== testbench/command_memory_model.sv ====
/*
  command memory and executor seen by the fault handler.
  assumes one fetch in flight and one offered command at a time.
*/
`timescale 1ns/100ps

module command_memory_model #(
  parameter int IDX_W = 8,
  parameter int CMD_W = 64
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // fetch
  input  wire logic             fetch_valid,
  input  wire logic [IDX_W-1:0] fetch_index,
  output logic                  fetch_ready,
  output logic                  rsp_valid,
  output logic [CMD_W-1:0]      rsp_data,
  output logic                  rsp_abort,
  // execution
  input  wire logic             exec_valid,
  input  wire logic [CMD_W-1:0] exec_cmd,
  output logic                  exec_done,
  output logic                  exec_sync_fail,
  // injected faults
  input  wire logic             abort_en,
  input  wire logic [IDX_W-1:0] abort_at,
  input  wire logic [7:0]       fail_op
);
  logic [CMD_W-1:0] mem [2**IDX_W];
  logic [CMD_W-1:0] log_q [$];
  logic [IDX_W-1:0] idx_q;
  logic [2:0]       cnt_q;
  logic             pend_q;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      fetch_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_abort <= 1'b0;
      exec_done <= 1'b0;
      exec_sync_fail <= 1'b0;
      cnt_q <= 3'h0;
      pend_q <= 1'b0;
    end
    else
    begin
      // ready every other cycle so requests see stalls
      fetch_ready <= ~fetch_ready;
      cnt_q <= cnt_q + 3'h1;
      rsp_valid <= 1'b0;
      // idle data bus never keeps the last word
      rsp_data <= ~rsp_data;
      rsp_abort <= 1'b0;
      exec_done <= 1'b0;
      exec_sync_fail <= 1'b0;
      if (fetch_valid && fetch_ready)
      begin
        pend_q <= 1'b1;
        idx_q <= fetch_index;
        cnt_q <= 3'h0;
      end
      else if (pend_q && cnt_q == 3'h3)
      begin
        pend_q <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_data <= mem[idx_q];
        rsp_abort <= abort_en && idx_q == abort_at;
      end
      // completion after a fixed wait, when the count since the fetch reaches 7
      if (exec_valid && !exec_done && cnt_q == 3'h7)
      begin
        exec_done <= 1'b1;
        exec_sync_fail <= exec_cmd[7:0] == fail_op;
        log_q.push_back(exec_cmd);
      end
    end

endmodule : command_memory_model

// ==== testbench/tb_command_queue_error_handler.sv ====
/*
  self-checking bench of the command queue fault handler.
  assumes the register map header and the memory model.
*/
`timescale 1ns/100ps
`include "cmdq_fault_params.svh"

module tb_command_queue_error_handler;
  logic        ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr, fail_op, abort_at, fetch_index;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  logic [63:0] rsp_data, exec_cmd;
  logic        fetch_valid, fetch_ready, rsp_valid, rsp_abort, exec_valid;
  logic        exec_done, exec_sync_fail, secure_queue, abort_en, flag;
  int          errors, n_checks;

  command_queue_error_handler u_command_queue_error_handler (
    .ref_clk (ref_clk), .rst_b (rst_b), .awaddr (awaddr),
    .awvalid (awvalid), .awready (awready), .wdata (wdata),
    .wstrb (wstrb), .wvalid (wvalid), .wready (wready),
    .bresp (bresp), .bvalid (bvalid), .bready (bready),
    .araddr (araddr), .arvalid (arvalid), .arready (arready),
    .rdata (rdata), .rresp (rresp), .rvalid (rvalid), .rready (rready),
    .fetch_valid (fetch_valid), .fetch_index (fetch_index),
    .fetch_ready (fetch_ready), .rsp_valid (rsp_valid),
    .rsp_data (rsp_data), .rsp_abort (rsp_abort),
    .exec_valid (exec_valid), .exec_cmd (exec_cmd),
    .exec_done (exec_done), .exec_sync_fail (exec_sync_fail),
    .secure_queue (secure_queue), .irq (irq)
  );
  command_memory_model u_command_memory_model (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .fetch_valid (fetch_valid), .fetch_index (fetch_index),
    .fetch_ready (fetch_ready), .rsp_valid (rsp_valid),
    .rsp_data (rsp_data), .rsp_abort (rsp_abort),
    .exec_valid (exec_valid), .exec_cmd (exec_cmd),
    .exec_done (exec_done), .exec_sync_fail (exec_sync_fail),
    .abort_en (abort_en), .abort_at (abort_at), .fail_op (fail_op)
  );

  task automatic chk(input string nm, input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // bready and rready stay high, which the bus allows
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    resp = bresp;
    chk("bvalid", bvalid, 1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready && arvalid) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    v = rdata;
    resp = rresp;
    chk("rvalid", rvalid, 1);
  endtask : rd

  task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
    int k;
    k = 0;
    do
    begin
      rd(a, d);
      k++;
    end while ((d & m) !== e && k < 200);
    chk("poll", d & m, e);
  endtask : poll

  // tog 0 re-checks a fault that is still standing
  task automatic fault(input logic [7:0] code, input logic [8:0] idx,
                       input int nlog, input bit tog);
    flag = flag ^ tog;
    poll(`OFS_GSTAT, 32'h1, {31'h0, flag});
    rd(`OFS_RPTR, d);
    chk("rptr", d, {code, 15'h0, idx});
    chk("executed", u_command_memory_model.log_q.size(), nlog);
  endtask : fault

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (50000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end

  initial
  begin
    {rst_b, awvalid, wvalid, arvalid, secure_queue, abort_en, flag} = '0;
    {awaddr, araddr, abort_at, wdata} = '0;
    {bready, rready, wstrb, fail_op} = {2'h3, 4'hf, 8'hff};
    {errors, n_checks} = '0;
    for (int i = 0; i < 8; i++)
      u_command_memory_model.mem[i] = 64'({8'h1, 8'h2, 8'h3, 8'h10,
                                             8'h4, 8'h6, 8'h7, 8'h5} >> (56 - 8 * i) & 64'hff);
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`OFS_RPTR, d);
    chk("rptr reset", d, `RST_WORD);
    rd(`OFS_GSTAT, d);
    chk("gstat reset", d, `RST_WORD);
    rd(8'h20, d);
    chk("unmapped", resp, `RESP_SLVERR);
    wr(8'h20, 32'h0);
    chk("wr unmapped", resp, `RESP_SLVERR);
    $display("test reset done");
    wr(`OFS_IEN, 32'h3);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_WPTR, 32'h3);
    poll(`OFS_RPTR, 32'h1ff, 32'h3);
    rd(`OFS_GSTAT, d);
    chk("no fault", d, 0);
    for (int i = 0; i < 3; i++)
      chk("order", u_command_memory_model.log_q[i], i + 1);
    rd(`OFS_ISTAT, d);
    chk("drained", d, 32'h2);
    chk("irq on", irq, 1);
    wr(`OFS_ICLR, 32'h2);
    rd(`OFS_ISTAT, d);
    chk("istat clr", d, 0);
    chk("irq off", irq, 0);
    $display("test consume done");
    wr(`OFS_WPTR, 32'h5);
    fault(`CODE_BAD_CMD, 9'h3, 3, 1'b1);
    chk("irq fault", irq, 1);
    wr(`OFS_IEN, 32'h2);
    rd(`OFS_ISTAT, d);
    chk("masked", irq, 0);
    wr(`OFS_ICLR, 32'h1);
    wr(`OFS_IEN, 32'h3);
    repeat (30) @(posedge ref_clk);
    fault(`CODE_BAD_CMD, 9'h3, 3, 1'b0);
    u_command_memory_model.mem[3] = 64'h2;
    wr(`OFS_GACK, {31'h0, flag});
    poll(`OFS_RPTR, 32'h1ff, 32'h5);
    chk("refetch", u_command_memory_model.log_q[3], 64'h2);
    $display("test illegal done");
    abort_at <= 8'h5;
    abort_en <= 1'b1;
    wr(`OFS_WPTR, 32'h6);
    fault(`CODE_FETCH_ABT, 9'h5, 5, 1'b1);
    abort_en <= 1'b0;
    wr(`OFS_WPTR, 32'h5);
    wr(`OFS_GACK, {31'h0, flag});
    repeat (30) @(posedge ref_clk);
    poll(`OFS_RPTR, 32'h1ff, 32'h5);
    chk("rewound", u_command_memory_model.log_q.size(), 5);
    $display("test abort done");
    wr(`OFS_WPTR, 32'h7);
    fault(`CODE_BAD_CMD, 9'h6, 6, 1'b1);
    secure_queue <= 1'b1;
    wr(`OFS_GACK, {31'h0, flag});
    poll(`OFS_RPTR, 32'h1ff, 32'h7);
    $display("test secure done");
    fail_op <= 8'h5;
    wr(`OFS_WPTR, 32'h8);
    fault(`CODE_INV_TMO, 9'h7, 8, 1'b1);
    fail_op <= 8'hff;
    wr(`OFS_GACK, {31'h0, flag});
    poll(`OFS_RPTR, 32'h1ff, 32'h8);
    chk("rerun", u_command_memory_model.log_q.size(), 9);
    $display("test sync done");
    print_verdict();
  end

endmodule : tb_command_queue_error_handler
